//--- common/skpmux_consts.vh
// Constants for the serial and key port pin multiplexer
`ifndef SKPMUX_CONSTS_VH
`define SKPMUX_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
`define SKPMUX_THIRD_DATA_ADDR 32'hFFFFF050
`define SKPMUX_SECOND_DATA_ADDR 32'hFFFFF051
`define SKPMUX_FIRST_DATA_ADDR 32'hFFFFF052
`define SKPMUX_THIRD_DIR_ADDR 32'hFFFFF054
`define SKPMUX_SECOND_DIR_ADDR 32'hFFFFF055
`define SKPMUX_FIRST_DIR_ADDR 32'hFFFFF056
`define SKPMUX_THIRD_FSEL_ADDR 32'hFFFFF058
`define SKPMUX_SECOND_FSEL_ADDR 32'hFFFFF059
`define SKPMUX_FIRST_FSEL_ADDR 32'hFFFFF05A
`define SKPMUX_THIRD_OD_ADDR 32'hFFFFF05C
`define SKPMUX_SECOND_OD_ADDR 32'hFFFFF05D
`define SKPMUX_FIRST_OD_ADDR 32'hFFFFF05E

// ****************************************
// Reset values and implemented bit masks
// ****************************************
`define SKPMUX_LATCH_RST 8'hFF
`define SKPMUX_CTRL_RST 8'h00
`define SKPMUX_FIRST_OD_MASK 8'h6D
`define SKPMUX_SECOND_OD_MASK 8'h5B
`define SKPMUX_THIRD_OD_MASK 8'h05

// ****************************************
// Field positions
// ****************************************
`define SKPMUX_SECOND_KEY_BIT 7
`define SKPMUX_THIRD_KEY_LO 3
`define SKPMUX_THIRD_KEY_HI 7
`endif

//--- hdl/skpmux_pad.v
// Per-pin output mux, open-drain control and readback for one port
`timescale 1ns/1ps
module skpmux_pad (
  input wire [7:0] latch, // Output latch
  input wire [7:0] dir, // Direction, 1 = output
  input wire [7:0] fsel, // Function select, 1 = peripheral
  input wire [7:0] od, // Open-drain enable
  input wire [7:0] alt, // Peripheral output values
  input wire [7:0] alt_oe, // Peripheral wants to drive
  input wire [7:0] pin_s, // Synchronised pin levels
  output reg [7:0] pad_out, // Pin drive value
  output reg [7:0] pad_oe, // Pin drive enable
  output reg [7:0] rd_val // Data register readback
);
  genvar gi;

  // ****************************************
  // Per-pin logic
  // ****************************************
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      reg val; // Value before open-drain shaping
      reg drv; // Drive request before open-drain shaping
      always @* begin
        val = fsel[gi] ? alt[gi] : latch[gi];
        drv = dir[gi] & (~fsel[gi] | alt_oe[gi]);
        // Open drain only pulls low; a high is left to the pull-up
        if (od[gi]) begin
          pad_out[gi] = 1'b0;
          pad_oe[gi] = drv & ~val;
        end else begin
          pad_out[gi] = val;
          pad_oe[gi] = drv;
        end
        // Outputs read back the latch, inputs read the pin
        rd_val[gi] = dir[gi] ? latch[gi] : pin_s[gi];
      end
    end
  endgenerate
endmodule

//--- hdl/skpmux_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module skpmux_sync (
  input wire clk, // System clock
  input wire rst, // Asynchronous reset, high
  input wire [7:0] pin_i, // Raw pin levels
  output reg [7:0] pin_s // Filtered synchronous levels
);
  reg [7:0] s1_q; // First stage, read only by the second
  reg [7:0] s2_q; // Second stage
  reg [7:0] s3_q; // Third stage
  genvar gi;

  // ****************************************
  // Per-bit stages
  // ****************************************
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
      // Level only moves once two settled stages agree, so a metastable blip never counts
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          pin_s[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= pin_i[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            pin_s[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate
endmodule

//--- hdl/skpmux_top.v
// Pin multiplexer for three serial and key wake-up ports
//
// Notes on behaviour
// - Second port direction: 0 input, 1 output
// - Reset clears second port direction and function
// - Third port direction: 0 input, 1 output
// - Reset clears third port direction and function
// - Reset leaves inputs, output latches set high
// - Function bit 0 port, 1 peripheral
// - Second pins 0,3,6: clock/CTS channels 2-4
// - Second pins 1,4: transmit channels 3,4
// - Second pins 2,5: receive channels 3,4
// - Second pin 7 is key line eight
// - Pin 7 pull-up needs key and pull-up enable
// - Pin 7 pull-up off as general I/O
// - Third pins 0-2: channel 5 transmit/receive/clock
// - Third pins 3-7 are key lines 9-13
// - Third pins 3-7 pull-up needs key enable
// - Third pins 3-7 pull-ups off as I/O
// - First port function bits map channels 0-2
// - First open-drain bits 0,2,3,5,6 only
// - Second open-drain bits 0,1,3,4,6, reset zero
// - First function and open-drain write-only, zero
// - Reset clears first port direction and function
`timescale 1ns/1ps
`include "skpmux_consts.vh"
module skpmux_top (
  input wire clk, // System clock, 25 MHz
  input wire rst, // Asynchronous reset, high
  input wire [31:0] addr, // Register byte address
  input wire [7:0] wr_data, // Register write data
  input wire wr_en, // Write strobe
  input wire rd_en, // Read strobe
  output reg [7:0] rd_data_q, // Read data, cycle after strobe
  input wire [7:0] first_pin_i, // First port pin levels
  output reg [7:0] first_pin_o_q, // First port pin drive value
  output reg [7:0] first_pin_oe_q, // First port pin drive enable
  input wire [7:0] second_pin_i, // Second port pin levels
  output reg [7:0] second_pin_o_q, // Second port pin drive value
  output reg [7:0] second_pin_oe_q, // Second port pin drive enable
  input wire [7:0] third_pin_i, // Third port pin levels
  output reg [7:0] third_pin_o_q, // Third port pin drive value
  output reg [7:0] third_pin_oe_q, // Third port pin drive enable
  input wire [5:0] ser_txd, // Channel transmit data
  output reg [5:0] ser_rxd_q, // Channel receive data
  input wire [5:0] ser_sclk_o, // Channel clock out value
  input wire [5:0] ser_sclk_oe, // Channel drives its clock
  output reg [5:0] ser_sclk_cts_q, // Channel clock in or clear-to-send
  output reg [5:0] key_line_q, // Key lines eight to thirteen
  input wire [5:0] key_line_setup, // Key input enabled per line
  input wire key_pullup_enable, // Wake-up block pull-up enable
  output reg second_port_pin7_pu_q, // Second port pin 7 pull-up on
  output reg [4:0] third_port_upper_pins_pu_q // Third port pins 3-7 pull-ups on
);

  // ****************************************
  // Register state
  // ****************************************
  reg [7:0] first_port_data_q; // First port output latch
  reg [7:0] second_port_data_q; // Second port output latch
  reg [7:0] third_port_data_q; // Third port output latch
  reg [7:0] first_port_direction_q; // First port direction
  reg [7:0] second_port_direction_q; // Second port direction
  reg [7:0] third_port_direction_q; // Third port direction
  reg [7:0] first_port_function_select_q; // First port function select
  reg [7:0] second_port_function_select_q; // Second port function select
  reg [7:0] third_port_function_select_q; // Third port function select
  reg [7:0] first_port_open_drain_q; // First port open-drain
  reg [7:0] second_port_open_drain_q; // Second port open-drain
  reg [7:0] third_port_open_drain_q; // Third port open-drain

  // ****************************************
  // Internal nets
  // ****************************************
  wire [7:0] first_s; // Synchronised first port pins
  wire [7:0] second_s; // Synchronised second port pins
  wire [7:0] third_s; // Synchronised third port pins
  reg [7:0] first_alt; // First port peripheral values
  reg [7:0] first_alt_oe; // First port peripheral drive
  reg [7:0] second_alt; // Second port peripheral values
  reg [7:0] second_alt_oe; // Second port peripheral drive
  reg [7:0] third_alt; // Third port peripheral values
  reg [7:0] third_alt_oe; // Third port peripheral drive
  wire [7:0] first_o; // First port drive value
  wire [7:0] first_oe; // First port drive enable
  wire [7:0] first_rd; // First port readback
  wire [7:0] second_o; // Second port drive value
  wire [7:0] second_oe; // Second port drive enable
  wire [7:0] second_rd; // Second port readback
  wire [7:0] third_o; // Third port drive value
  wire [7:0] third_oe; // Third port drive enable
  wire [7:0] third_rd; // Third port readback
  reg [5:0] rxd_d; // Next receive data
  reg [5:0] sclk_d; // Next clock or CTS inputs
  reg [5:0] key_d; // Next key line levels
  reg [7:0] rd_data_d; // Next read data

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // One filter per port
  skpmux_sync u_first_sync (
    .clk(clk),
    .rst(rst),
    .pin_i(first_pin_i),
    .pin_s(first_s)
  );

  skpmux_sync u_second_sync (
    .clk(clk),
    .rst(rst),
    .pin_i(second_pin_i),
    .pin_s(second_s)
  );

  skpmux_sync u_third_sync (
    .clk(clk),
    .rst(rst),
    .pin_i(third_pin_i),
    .pin_s(third_s)
  );

  // ****************************************
  // Register writes
  // ****************************************
  // Reset puts every pin back to a general input with latch high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      first_port_data_q <= `SKPMUX_LATCH_RST;
      second_port_data_q <= `SKPMUX_LATCH_RST;
      third_port_data_q <= `SKPMUX_LATCH_RST;
      first_port_direction_q <= `SKPMUX_CTRL_RST;
      second_port_direction_q <= `SKPMUX_CTRL_RST;
      third_port_direction_q <= `SKPMUX_CTRL_RST;
      first_port_function_select_q <= `SKPMUX_CTRL_RST;
      second_port_function_select_q <= `SKPMUX_CTRL_RST;
      third_port_function_select_q <= `SKPMUX_CTRL_RST;
      first_port_open_drain_q <= `SKPMUX_CTRL_RST;
      second_port_open_drain_q <= `SKPMUX_CTRL_RST;
      third_port_open_drain_q <= `SKPMUX_CTRL_RST;
    end else if (wr_en) begin
      case (addr)
        // Output latches
        `SKPMUX_FIRST_DATA_ADDR: begin
          first_port_data_q <= wr_data;
        end
        `SKPMUX_SECOND_DATA_ADDR: begin
          second_port_data_q <= wr_data;
        end
        `SKPMUX_THIRD_DATA_ADDR: begin
          third_port_data_q <= wr_data;
        end
        // Directions
        `SKPMUX_FIRST_DIR_ADDR: begin
          first_port_direction_q <= wr_data;
        end
        `SKPMUX_SECOND_DIR_ADDR: begin
          second_port_direction_q <= wr_data;
        end
        `SKPMUX_THIRD_DIR_ADDR: begin
          third_port_direction_q <= wr_data;
        end
        // Function selects
        `SKPMUX_FIRST_FSEL_ADDR: begin
          first_port_function_select_q <= wr_data;
        end
        `SKPMUX_SECOND_FSEL_ADDR: begin
          second_port_function_select_q <= wr_data;
        end
        `SKPMUX_THIRD_FSEL_ADDR: begin
          third_port_function_select_q <= wr_data;
        end
        // Unused open-drain positions never store, so they cannot alter a pin
        `SKPMUX_FIRST_OD_ADDR: begin
          first_port_open_drain_q <= wr_data & `SKPMUX_FIRST_OD_MASK;
        end
        `SKPMUX_SECOND_OD_ADDR: begin
          second_port_open_drain_q <= wr_data & `SKPMUX_SECOND_OD_MASK;
        end
        `SKPMUX_THIRD_OD_ADDR: begin
          third_port_open_drain_q <= wr_data & `SKPMUX_THIRD_OD_MASK;
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
  end

  // ****************************************
  // Peripheral output routing
  // ****************************************
  // Transmit pins drive when selected and set as outputs; clock pins also need the channel to be master
  always @* begin
    // First port: ch0 tx/rx/clk, ch1 tx/rx/clk, ch2 tx/rx
    first_alt = {1'b1, ser_txd[2], ser_sclk_o[1], 1'b1,
      ser_txd[1], ser_sclk_o[0], 1'b1, ser_txd[0]};
    first_alt_oe = {1'b0, 1'b1, ser_sclk_oe[1], 1'b0,
      1'b1, ser_sclk_oe[0], 1'b0, 1'b1};
    // Second port: ch2 clk, ch3 tx/rx/clk, ch4 tx/rx/clk, key eight
    second_alt = {1'b1, ser_sclk_o[4], 1'b1, ser_txd[4],
      ser_sclk_o[3], 1'b1, ser_txd[3], ser_sclk_o[2]};
    second_alt_oe = {1'b0, ser_sclk_oe[4], 1'b0, 1'b1,
      ser_sclk_oe[3], 1'b0, 1'b1, ser_sclk_oe[2]};
    // Third port: ch5 tx/rx/clk, keys nine to thirteen
    third_alt = {5'h1F, ser_sclk_o[5], 1'b1, ser_txd[5]};
    third_alt_oe = {5'h00, ser_sclk_oe[5], 1'b0, 1'b1};
  end

  // ****************************************
  // Pad logic per port
  // ****************************************
  // Same pad slice for every port
  skpmux_pad u_first_pad (
    .latch(first_port_data_q),
    .dir(first_port_direction_q),
    .fsel(first_port_function_select_q),
    .od(first_port_open_drain_q),
    .alt(first_alt),
    .alt_oe(first_alt_oe),
    .pin_s(first_s),
    .pad_out(first_o),
    .pad_oe(first_oe),
    .rd_val(first_rd)
  );

  skpmux_pad u_second_pad (
    .latch(second_port_data_q),
    .dir(second_port_direction_q),
    .fsel(second_port_function_select_q),
    .od(second_port_open_drain_q),
    .alt(second_alt),
    .alt_oe(second_alt_oe),
    .pin_s(second_s),
    .pad_out(second_o),
    .pad_oe(second_oe),
    .rd_val(second_rd)
  );

  skpmux_pad u_third_pad (
    .latch(third_port_data_q),
    .dir(third_port_direction_q),
    .fsel(third_port_function_select_q),
    .od(third_port_open_drain_q),
    .alt(third_alt),
    .alt_oe(third_alt_oe),
    .pin_s(third_s),
    .pad_out(third_o),
    .pad_oe(third_oe),
    .rd_val(third_rd)
  );

  // ****************************************
  // Peripheral input routing
  // ****************************************
  // Deselected inputs idle high so a channel sees a quiet line, not port traffic
  always @* begin
    rxd_d[0] = first_port_function_select_q[1] ? first_s[1] : 1'b1;
    rxd_d[1] = first_port_function_select_q[4] ? first_s[4] : 1'b1;
    rxd_d[2] = first_port_function_select_q[7] ? first_s[7] : 1'b1;
    rxd_d[3] = second_port_function_select_q[2] ? second_s[2] : 1'b1;
    rxd_d[4] = second_port_function_select_q[5] ? second_s[5] : 1'b1;
    rxd_d[5] = third_port_function_select_q[1] ? third_s[1] : 1'b1;
    sclk_d[0] = first_port_function_select_q[2] ? first_s[2] : 1'b1;
    sclk_d[1] = first_port_function_select_q[5] ? first_s[5] : 1'b1;
    sclk_d[2] = second_port_function_select_q[0] ? second_s[0] : 1'b1;
    sclk_d[3] = second_port_function_select_q[3] ? second_s[3] : 1'b1;
    sclk_d[4] = second_port_function_select_q[6] ? second_s[6] : 1'b1;
    sclk_d[5] = third_port_function_select_q[2] ? third_s[2] : 1'b1;
    // Key lines idle high (no key pressed) when not selected
    key_d[0] = second_port_function_select_q[`SKPMUX_SECOND_KEY_BIT] ?
      second_s[`SKPMUX_SECOND_KEY_BIT] : 1'b1;
    key_d[5:1] = third_s[`SKPMUX_THIRD_KEY_HI:`SKPMUX_THIRD_KEY_LO] |
      ~third_port_function_select_q[`SKPMUX_THIRD_KEY_HI:`SKPMUX_THIRD_KEY_LO];
  end

  // ****************************************
  // Read decode
  // ****************************************
  // Control registers are write-only and read as zero, like unmapped space
  always @* begin
    rd_data_d = 8'h00;
    if (rd_en) begin
      case (addr)
        `SKPMUX_FIRST_DATA_ADDR: begin
          rd_data_d = first_rd;
        end
        `SKPMUX_SECOND_DATA_ADDR: begin
          rd_data_d = second_rd;
        end
        `SKPMUX_THIRD_DATA_ADDR: begin
          rd_data_d = third_rd;
        end
        default: begin
          rd_data_d = 8'h00;
        end
      endcase
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  // Every output leaves a flop; costs a cycle of pin latency, removes glitches
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= 8'h00;
      first_pin_o_q <= 8'h00;
      first_pin_oe_q <= 8'h00;
      second_pin_o_q <= 8'h00;
      second_pin_oe_q <= 8'h00;
      third_pin_o_q <= 8'h00;
      third_pin_oe_q <= 8'h00;
      ser_rxd_q <= 6'h3F;
      ser_sclk_cts_q <= 6'h3F;
      key_line_q <= 6'h3F;
      second_port_pin7_pu_q <= 1'b0;
      third_port_upper_pins_pu_q <= 5'h00;
    end else begin
      rd_data_q <= rd_data_d;
      // Pin drives
      first_pin_o_q <= first_o;
      first_pin_oe_q <= first_oe;
      second_pin_o_q <= second_o;
      second_pin_oe_q <= second_oe;
      third_pin_o_q <= third_o;
      third_pin_oe_q <= third_oe;
      // Peripheral and key inputs
      ser_rxd_q <= rxd_d;
      ser_sclk_cts_q <= sclk_d;
      key_line_q <= key_d;
      // Pull-up needs key mode, line enable and the global enable
      second_port_pin7_pu_q <= second_port_function_select_q[`SKPMUX_SECOND_KEY_BIT] &
        key_line_setup[0] & key_pullup_enable;
      third_port_upper_pins_pu_q <=
        third_port_function_select_q[`SKPMUX_THIRD_KEY_HI:`SKPMUX_THIRD_KEY_LO] &
        key_line_setup[5:1] & {5{key_pullup_enable}};
    end
  end

endmodule

//--- tb/skpmux_board.sv
// Board model for one port of the pin multiplexer
`timescale 1ns/1ps
module skpmux_board (
  input wire [7:0] pin_o, // Device drive value
  input wire [7:0] pin_oe, // Device drive enable
  input wire [7:0] ext, // Board level on an undriven pin
  output wire [7:0] pin_i // Resolved pin level
);
  // ********************************
  // Pin resolution
  // ********************************
  // A released pin takes the board level, never a stale device value
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

//--- tb/skpmux_checker.sv
// Port-level assertions for the pin multiplexer
`timescale 1ns/1ps
module skpmux_checker (
  input wire clk, // System clock
  input wire rst, // Reset, high
  input wire [31:0] addr, // Address
  input wire [7:0] wr_data, // Write data
  input wire wr_en, // Write strobe
  input wire rd_en, // Read strobe
  input wire [7:0] rd_data_q, // Read data
  input wire [7:0] first_pin_oe_q, // First port drive enable
  input wire [7:0] second_pin_oe_q, // Second port drive enable
  input wire [7:0] third_pin_oe_q, // Third port drive enable
  input wire [5:0] ser_rxd_q, // Receive data
  input wire [5:0] ser_sclk_cts_q, // Clock in or CTS
  input wire [5:0] key_line_q, // Key lines
  input wire [5:0] key_line_setup, // Key enables
  input wire key_pullup_enable, // Pull-up enable
  input wire second_port_pin7_pu_q, // Pin 7 pull-up
  input wire [4:0] third_port_upper_pins_pu_q // Pins 3-7 pull-ups
);
  // ********************************
  // Shadow copies of the function selects
  // ********************************
  reg [7:0] fs1_q; // First port function select
  reg [7:0] fs2_q; // Second port function select
  reg [7:0] fs3_q; // Third port function select

  // Selects are write-only, so mirror each write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fs1_q <= 8'h00;
      fs2_q <= 8'h00;
      fs3_q <= 8'h00;
    end else if (wr_en) begin
      if (addr == 32'hFFFFF05A) fs1_q <= wr_data;
      if (addr == 32'hFFFFF059) fs2_q <= wr_data;
      if (addr == 32'hFFFFF058) fs3_q <= wr_data;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ********************************
  // Assertions
  // ********************************
  a_read_idle: assert property (!$past(rd_en) |-> rd_data_q == 8'h00)
    else $error("Read data not zero outside its slot");
  a_ctrl_read_zero: assert property (rd_en && addr[31:4] == 28'hFFFFF05 && addr[3:2] != 2'b00 |=>
    rd_data_q == 8'h00) else $error("Write-only register read nonzero");
  a_unmapped_read: assert property (rd_en && addr == 32'hFFFFF053 |=> rd_data_q == 8'h00)
    else $error("Unmapped read nonzero");
  a_reset_no_drive: assert property ($past(rst) |->
    (first_pin_oe_q | second_pin_oe_q | third_pin_oe_q) == 8'h00) else $error("Pin driven after reset");
  a_dir2_clear: assert property (wr_en && addr == 32'hFFFFF055 && wr_data == 8'h00 |->
    ##2 second_pin_oe_q == 8'h00) else $error("Second port drives with direction clear");
  a_dir3_clear: assert property (wr_en && addr == 32'hFFFFF054 && wr_data == 8'h00 |->
    ##2 third_pin_oe_q == 8'h00) else $error("Third port drives with direction clear");
  a_key_line_eight_pullup: assert property (second_port_pin7_pu_q ==
    $past(fs2_q[7] & key_line_setup[0] & key_pullup_enable)) else $error("Pin 7 pull-up wrong");
  a_key_pullups: assert property (third_port_upper_pins_pu_q ==
    $past(fs3_q[7:3] & key_line_setup[5:1] & {5{key_pullup_enable}})) else $error("Upper pull-ups wrong");
  a_key_line_eight_idle: assert property (!fs2_q[7] [*6] |-> key_line_q[0])
    else $error("Key line eight active while deselected");
  a_rx5_idle: assert property (!fs3_q[1] [*6] |-> ser_rxd_q[5])
    else $error("Channel five receive not idle");
  a_cts0_idle: assert property (!fs1_q[2] [*6] |-> ser_sclk_cts_q[0])
    else $error("Channel zero clock in not idle");

  c_read: cover property (rd_en ##1 rd_data_q != 8'h00);
  c_pin7_pullup: cover property ($rose(second_port_pin7_pu_q));
  c_upper_pullup: cover property ($rose(|third_port_upper_pins_pu_q));
endmodule

//--- tb/skpmux_tb.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`include "skpmux_consts.vh"
module skpmux_tb;
  // ********************************
  // Stimulus, wires and model state
  // ********************************
  logic clk = 1'b0; // System clock
  logic rst = 1'b1; // Reset, high
  logic [31:0] addr = 32'h0; // Bus address
  logic [7:0] wr_data = 8'h00; // Bus write data
  logic wr_en = 1'b0; // Write strobe
  logic rd_en = 1'b0; // Read strobe
  logic [7:0] ext [3]; // Board levels, index 0 = first port
  logic [5:0] ser_txd = 6'h00; // Transmit data
  logic [5:0] ser_sclk_o = 6'h00; // Clock out values
  logic [5:0] ser_sclk_oe = 6'h00; // Clock drive requests
  logic [5:0] key_line_setup = 6'h00; // Key enables
  logic key_pullup_enable = 1'b0; // Pull-up enable
  wire [7:0] rd_data_q; // Read data
  wire [7:0] pin_i [3]; // Resolved pin levels
  wire [7:0] pin_o [3]; // Drive values
  wire [7:0] pin_oe [3]; // Drive enables
  wire [5:0] ser_rxd_q, ser_sclk_cts_q, key_line_q; // Peripheral inputs
  wire pu7; // Pin 7 pull-up
  wire [4:0] pu3; // Pins 3-7 pull-ups
  logic [7:0] lat [3], dr [3], fs [3], od [3]; // Model registers
  logic [7:0] odm [3] = '{`SKPMUX_FIRST_OD_MASK, `SKPMUX_SECOND_OD_MASK, `SKPMUX_THIRD_OD_MASK};
  // Pin kind (0 transmit, 1 receive, 2 clock, 3 key) and channel or key index
  int kd [3][8] = '{'{0, 1, 2, 0, 1, 2, 0, 1}, '{2, 0, 1, 2, 0, 1, 2, 3}, '{0, 1, 2, 3, 3, 3, 3, 3}};
  int ch [3][8] = '{'{0, 0, 0, 1, 1, 1, 2, 2}, '{2, 3, 3, 3, 4, 4, 4, 0}, '{5, 5, 5, 1, 2, 3, 4, 5}};
  int fails = 0; // Mismatches
  int checks_done = 0; // Comparisons
  integer seed = 32'hAC68; // Random seed

  skpmux_top DUT (.clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q, .first_pin_i(pin_i[0]),
    .first_pin_o_q(pin_o[0]), .first_pin_oe_q(pin_oe[0]), .second_pin_i(pin_i[1]), .second_pin_o_q(pin_o[1]),
    .second_pin_oe_q(pin_oe[1]), .third_pin_i(pin_i[2]), .third_pin_o_q(pin_o[2]), .third_pin_oe_q(pin_oe[2]),
    .ser_txd, .ser_rxd_q, .ser_sclk_o, .ser_sclk_oe, .ser_sclk_cts_q, .key_line_q, .key_line_setup,
    .key_pullup_enable, .second_port_pin7_pu_q(pu7), .third_port_upper_pins_pu_q(pu3));

  // One board model per port
  for (genvar g = 0; g < 3; g++) begin : g_brd
    skpmux_board u_brd (.pin_o(pin_o[g]), .pin_oe(pin_oe[g]), .ext(ext[g]), .pin_i(pin_i[g]));
  end

  // Clock, 40 ns period
  always #20 clk = ~clk;

  // ********************************
  // Tasks
  // ********************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset image: latches high, all else clear
  task automatic model_reset();
    lat = '{3{8'hFF}};
    dr = '{3{8'h00}};
    fs = '{3{8'h00}};
    od = '{3{8'h00}};
  endtask

  // Bus write; unmapped slots leave the model untouched
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    int p;
    p = 2 - int'(a[1:0]);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    if (p >= 0) begin
      case (a[3:2])
        2'd0: lat[p] = d;
        2'd1: dr[p] = d;
        2'd2: fs[p] = d;
        default: od[p] = d & odm[p];
      endcase
    end
  endtask

  // Bus read; data is looked at in the one cycle it stands
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 cmp(rd_data_q, e);
  endtask

  // Read all sixteen slots, data registers first
  task automatic read_all();
    logic [7:0] e;
    for (int r = 0; r < 16; r++) begin
      e = 8'h00;
      if (r < 3) e = (dr[2 - r] & lat[2 - r]) | (~dr[2 - r] & ext[2 - r]);
      rd(32'hFFFFF050 + r, e);
    end
  endtask

  // Filter and output flops need six edges; eight is ample
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask

  // Compare all pin and peripheral outputs
  task automatic check_pins();
    logic [7:0] eo, ee, pv;
    logic [7:0] erx, ecl, eky;
    logic v, drv;
    int k, c;
    erx = 8'h3F;
    ecl = 8'h3F;
    eky = 8'h3F;
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 8; b++) begin
        k = kd[p][b];
        c = ch[p][b];
        v = (k == 0) ? ser_txd[c] : (k == 2) ? ser_sclk_o[c] : 1'b0;
        drv = (k == 0) | ((k == 2) & ser_sclk_oe[c]);
        // General-purpose pin takes the latch
        if (!fs[p][b]) begin
          v = lat[p][b];
          drv = 1'b1;
        end
        drv = drv & dr[p][b];
        eo[b] = od[p][b] ? 1'b0 : v;
        ee[b] = od[p][b] ? (drv & ~v) : drv;
        pv[b] = ee[b] ? eo[b] : ext[p][b];
        if (fs[p][b] && k == 1) erx[c] = pv[b];
        if (fs[p][b] && k == 2) ecl[c] = pv[b];
        if (fs[p][b] && k == 3) eky[c] = pv[b];
      end
      cmp(pin_oe[p], ee);
      cmp(pin_o[p] & (ee | od[p]), eo & (ee | od[p]));
    end
    cmp({2'b00, ser_rxd_q}, erx);
    cmp({2'b00, ser_sclk_cts_q}, ecl);
    cmp({2'b00, key_line_q}, eky);
    cmp({7'h00, pu7}, {7'h00, fs[1][7] & key_line_setup[0] & key_pullup_enable});
    cmp({3'h0, pu3}, {3'h0, fs[2][7:3] & key_line_setup[5:1] & {5{key_pullup_enable}}});
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    ext = '{3{8'hA5}};
    model_reset();
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle();
    check_pins();
    read_all();
    $display("Test reset_state finished");
    for (int p = 0; p < 3; p++) begin
      wr(32'hFFFFF054 + p, 8'hFF);
    end
    settle();
    check_pins();
    $display("Test reset_latch finished");
    // Random setups, unmapped slots included
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      for (int p = 0; p < 3; p++) begin
        ext[p] <= 8'($random(seed));
      end
      ser_txd <= 6'($random(seed));
      ser_sclk_o <= 6'($random(seed));
      ser_sclk_oe <= 6'($random(seed));
      key_line_setup <= 6'($random(seed));
      key_pullup_enable <= 1'($random(seed));
      for (int r = 0; r < 16; r++) begin
        wr(32'hFFFFF050 + r, 8'($random(seed)));
      end
      settle();
      check_pins();
      read_all();
    end
    $display("Test random_mux finished");
    for (int p = 0; p < 3; p++) begin
      wr(32'hFFFFF054 + p, 8'h00);
    end
    settle();
    check_pins();
    $display("Test direction_clear finished");
    // Mid-run reset restores the reset image
    @(posedge clk);
    rst <= 1'b1;
    model_reset();
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    check_pins();
    read_all();
    $display("Test mid_reset finished");
    wrap_up();
  end

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end
endmodule

bind skpmux_top skpmux_checker u_chk (.clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data_q, .first_pin_oe_q,
  .second_pin_oe_q, .third_pin_oe_q, .ser_rxd_q, .ser_sclk_cts_q, .key_line_q, .key_line_setup, .key_pullup_enable,
  .second_port_pin7_pu_q, .third_port_upper_pins_pu_q);
